// ### cpu_slice_pkg.sv
// Constants, field layouts and types shared by the execution slice.
package cpu_slice_pkg;

  // Clock rate of the single system clock.
  localparam int unsigned CLK_HZ = 40_000_000;

  // Widths of the core.
  localparam int unsigned DATA_W = 8;
  localparam int unsigned NUM_REGS = 32;
  localparam int unsigned NUM_IO = 32;
  localparam int unsigned PTR_W = 16;

  ////////////////////////////////////////////////////////////////////////////
  // Register bus byte offsets.
  localparam logic [9:0] ADR_CMD = 10'h000;
  localparam logic [9:0] ADR_STATUS = 10'h004;
  localparam logic [9:0] ADR_PC = 10'h008;
  localparam logic [9:0] ADR_STATUS_FLAGS_REGISTER = 10'h00C;
  localparam logic [2:0] BANK_REGS = 3'h2;
  localparam logic [2:0] BANK_IO = 3'h4;
  localparam logic [2:0] BANK_CTRL = 3'h0;

  // Status word field positions.
  localparam int unsigned ST_BUSY_BIT = 0;
  localparam int unsigned ST_CYC_LSB = 8;

  // Bit positions inside status_flags_register.
  localparam logic [2:0] FLG_C = 3'h0;
  localparam logic [2:0] FLG_Z = 3'h1;
  localparam logic [2:0] FLG_N = 3'h2;
  localparam logic [2:0] FLG_V = 3'h3;
  localparam logic [2:0] FLG_T = 3'h6;
  localparam logic [2:0] FLG_I = 3'h7;

  // Low register of each pointer pair.
  localparam logic [4:0] PTR_X_LO = 5'h1A;
  localparam logic [4:0] PTR_Y_LO = 5'h1C;
  localparam logic [4:0] PTR_Z_LO = 5'h1E;

  // Values after reset and cycle counts.
  localparam logic [15:0] PC_RST = 16'h0000;
  localparam logic [7:0] STATUS_FLAGS_REGISTER_RST = 8'h00;
  localparam logic [1:0] CYC_ONE = 2'h1;
  localparam logic [1:0] CYC_TWO = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  // Instruction codes carried in the command word.
  typedef enum logic [4:0] {
    OP_NOP = 5'h00, OP_BR_V_SET = 5'h01, OP_BR_V_CLR = 5'h02,
    OP_BR_I_SET = 5'h03, OP_BR_I_CLR = 5'h04, OP_IO_SET = 5'h05,
    OP_IO_CLR = 5'h06, OP_LSL = 5'h07, OP_LSR = 5'h08, OP_ROL = 5'h09,
    OP_ROR = 5'h0A, OP_ASR = 5'h0B, OP_SWAP = 5'h0C, OP_FLAG_SET = 5'h0D,
    OP_FLAG_CLR = 5'h0E, OP_BST = 5'h0F, OP_BLD = 5'h10, OP_MOV = 5'h11,
    OP_REG_PAIR_COPY = 5'h12, OP_LDI = 5'h13, OP_LD = 5'h14, OP_LD_INC = 5'h15,
    OP_LD_DEC = 5'h16, OP_LD_DISP = 5'h17
  } op_e;

  // Command word layout, least significant field last.
  typedef struct packed {
    logic [5:0] pad;
    logic [7:0] imm;
    logic [2:0] bit_sel;
    logic [4:0] src;
    logic [4:0] dst;
    op_e op;
  } cmd_s;

  // Data memory read request.
  typedef struct packed {
    logic rd;
    logic [15:0] addr;
  } dmem_req_s;

  // Execution states, one-hot.
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_EXEC1 = 3'b010,
    ST_EXEC2 = 3'b100
  } state_e;

endpackage

// ### cpu_bit_flag_load_exec.sv
// Execution slice: flag branches, bit ops, shifts, flag ops and pointer loads.
// Function
// - Overflow branches jump PC+k+1 on V set/clear; 1 cycle untaken, 2 taken.
// - Interrupt branches jump on I one/zero; no flags change; 1 or 2 cycles.
// - I/O bit set writes one to chosen bit in two cycles, flags kept.
// - I/O bit clear writes zero to chosen bit in two cycles, flags kept.
// - Logical left shift, zero into bit 0, updates Z C N V, one cycle.
// - Logical right shift, zero into bit 7, updates Z C N V, one cycle.
// - Rotate left through carry, bit 7 to carry, Z N V updated, one cycle.
// - Rotate right through carry, bit 0 to carry, Z N V updated, one cycle.
// - Arithmetic right shift keeps bit 7, updates Z C N V, one cycle.
// - Nibble swap exchanges register halves in one cycle, flags untouched.
// - Generic flag set/clear writes operand-selected status bit, one cycle.
// - Bit store copies selected source bit into transfer flag, one cycle.
// - Bit load copies transfer flag into destination bit, one cycle.
// - Post-increment load reads at pointer then adds one; two cycles.
// - Pre-decrement load subtracts one then reads; two cycles, flags kept.
// - Displacement load reads pointer plus offset, pointer kept, two cycles.
module cpu_bit_flag_load_exec #(
  parameter int unsigned PC_W = 16
) (
  // Clock and reset.
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  // Classic Wishbone slave.
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [9:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Data memory read port, combinational read data.
  output cpu_slice_pkg::dmem_req_s dmem_req_o,
  input wire logic [7:0] dmem_rdata_i
);

  // The PC readback and branch arithmetic assume between 9 and 16 bits,
  // since the upper byte lane of the PC write needs at least one bit.
  if (PC_W < 9 || PC_W > 16) begin : g_bad_pc_w
    $error("PC_W must lie between 9 and 16");
  end

  // Selects the register bank that a bus address falls in.
  function automatic logic [2:0] bank_of(input logic [9:0] adr);
    bank_of = adr[9:7];
  endfunction

  // Low register index of the pointer pair named by a two-bit selector.
  function automatic logic [4:0] ptr_lo(input logic [1:0] sel);
    case (sel)
      2'h0: ptr_lo = cpu_slice_pkg::PTR_X_LO;
      2'h1: ptr_lo = cpu_slice_pkg::PTR_Y_LO;
      default: ptr_lo = cpu_slice_pkg::PTR_Z_LO;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Reset release through two flip-flops; assertion stays asynchronous.
  logic [1:0] rst_sync_q;
  logic rst_n;

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_q[1];

  ////////////////////////////////////////////////////////////////////////////
  // Core state.
  cpu_slice_pkg::state_e state_q, state_d;
  cpu_slice_pkg::cmd_s cmd_q, cmd_d;
  cpu_slice_pkg::dmem_req_s dreq_q, dreq_d;
  logic [PC_W-1:0] pc_q, pc_d;
  logic [7:0] status_flags_register_q, status_flags_register_d;
  logic [1:0] last_q, last_d;
  logic [7:0] regs_q [cpu_slice_pkg::NUM_REGS];
  logic [7:0] regs_d [cpu_slice_pkg::NUM_REGS];
  logic [7:0] io_q [cpu_slice_pkg::NUM_IO];
  logic [7:0] io_d [cpu_slice_pkg::NUM_IO];
  logic ack_q, ack_d;
  logic [31:0] dat_q, dat_d;
  logic wr_fire;

  // A bus write lands at the same edge that raises ack.
  assign wr_fire = wb_cyc_i && wb_stb_i && wb_we_i && !ack_q;

  ////////////////////////////////////////////////////////////////////////////
  // Bus answer: ack one cycle after the request, read data with it.
  always_comb begin
    logic [31:0] st;
    st = '0;
    st[cpu_slice_pkg::ST_BUSY_BIT] = (state_q != cpu_slice_pkg::ST_IDLE);
    st[cpu_slice_pkg::ST_CYC_LSB +: 2] = last_q;
    ack_d = wb_cyc_i && wb_stb_i && !ack_q;
    dat_d = 32'h0000_0000;
    if (ack_d && !wb_we_i) begin
      case (bank_of(wb_adr_i))
        cpu_slice_pkg::BANK_CTRL: begin
          case ({wb_adr_i[9:2], 2'h0})
            cpu_slice_pkg::ADR_CMD: dat_d = 32'(cmd_q);
            cpu_slice_pkg::ADR_STATUS: dat_d = st;
            cpu_slice_pkg::ADR_PC: dat_d = 32'(pc_q);
            cpu_slice_pkg::ADR_STATUS_FLAGS_REGISTER: dat_d = 32'(status_flags_register_q);
            default: dat_d = 32'h0000_0000;
          endcase
        end
        cpu_slice_pkg::BANK_REGS: dat_d = 32'(regs_q[wb_adr_i[6:2]]);
        cpu_slice_pkg::BANK_IO: dat_d = 32'(io_q[wb_adr_i[6:2]]);
        default: dat_d = 32'h0000_0000;
      endcase
    end
  end

  // Answer registers.
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0000_0000;
    end else begin
      ack_q <= ack_d;
      dat_q <= dat_d;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;
  assign dmem_req_o = dreq_q;

  ////////////////////////////////////////////////////////////////////////////
  // Instruction execution and bus writes. Bus writes are dropped while an
  // instruction runs, so software never races the datapath on a register.
  always_comb begin
    logic [7:0] rd_v;
    logic [7:0] res;
    logic c_new;
    logic take;
    logic [4:0] plo;
    logic [15:0] ptr;
    logic [15:0] ptr_new;
    logic [PC_W-1:0] koff;
    rd_v = regs_q[cmd_q.dst];
    res = rd_v;
    c_new = status_flags_register_q[cpu_slice_pkg::FLG_C];
    take = 1'b0;
    plo = ptr_lo(cmd_q.src[1:0]);
    ptr = {regs_q[5'(plo + 5'h01)], regs_q[plo]};
    ptr_new = ptr;
    koff = PC_W'({{9{cmd_q.imm[6]}}, cmd_q.imm[6:0]});
    state_d = state_q;
    cmd_d = cmd_q;
    pc_d = pc_q;
    status_flags_register_d = status_flags_register_q;
    last_d = last_q;
    regs_d = regs_q;
    io_d = io_q;
    dreq_d = dreq_q;
    dreq_d.rd = 1'b0;
    case (state_q)
      cpu_slice_pkg::ST_IDLE: begin
        if (wr_fire) begin
          case (bank_of(wb_adr_i))
            cpu_slice_pkg::BANK_CTRL: begin
              if ({wb_adr_i[9:2], 2'h0} == cpu_slice_pkg::ADR_CMD && wb_sel_i == 4'hF) begin
                cmd_d = cpu_slice_pkg::cmd_s'(wb_dat_i);
                state_d = cpu_slice_pkg::ST_EXEC1;
              end
              if ({wb_adr_i[9:2], 2'h0} == cpu_slice_pkg::ADR_PC) begin
                if (wb_sel_i[0]) begin
                  pc_d[7:0] = wb_dat_i[7:0];
                end
                if (wb_sel_i[1]) begin
                  pc_d[PC_W-1:8] = wb_dat_i[PC_W-1:8];
                end
              end
              if ({wb_adr_i[9:2], 2'h0} == cpu_slice_pkg::ADR_STATUS_FLAGS_REGISTER && wb_sel_i[0]) begin
                status_flags_register_d = wb_dat_i[7:0];
              end
            end
            cpu_slice_pkg::BANK_REGS: begin
              if (wb_sel_i[0]) begin
                regs_d[wb_adr_i[6:2]] = wb_dat_i[7:0];
              end
            end
            cpu_slice_pkg::BANK_IO: begin
              if (wb_sel_i[0]) begin
                io_d[wb_adr_i[6:2]] = wb_dat_i[7:0];
              end
            end
            default: begin
            end
          endcase
        end
      end
      cpu_slice_pkg::ST_EXEC1: begin
        // Every instruction here is one word long.
        pc_d = pc_q + PC_W'(1);
        state_d = cpu_slice_pkg::ST_IDLE;
        last_d = cpu_slice_pkg::CYC_ONE;
        case (cmd_q.op)
          cpu_slice_pkg::OP_BR_V_SET, cpu_slice_pkg::OP_BR_V_CLR,
          cpu_slice_pkg::OP_BR_I_SET, cpu_slice_pkg::OP_BR_I_CLR: begin
            case (cmd_q.op)
              cpu_slice_pkg::OP_BR_V_SET: take = status_flags_register_q[cpu_slice_pkg::FLG_V];
              cpu_slice_pkg::OP_BR_V_CLR: take = !status_flags_register_q[cpu_slice_pkg::FLG_V];
              cpu_slice_pkg::OP_BR_I_SET: take = status_flags_register_q[cpu_slice_pkg::FLG_I];
              default: take = !status_flags_register_q[cpu_slice_pkg::FLG_I];
            endcase
            if (take) begin
              pc_d = pc_q + koff + PC_W'(1);
              state_d = cpu_slice_pkg::ST_EXEC2;
            end
          end
          cpu_slice_pkg::OP_IO_SET: state_d = cpu_slice_pkg::ST_EXEC2;
          cpu_slice_pkg::OP_IO_CLR: state_d = cpu_slice_pkg::ST_EXEC2;
          cpu_slice_pkg::OP_LSL, cpu_slice_pkg::OP_LSR, cpu_slice_pkg::OP_ROL,
          cpu_slice_pkg::OP_ROR, cpu_slice_pkg::OP_ASR: begin
            case (cmd_q.op)
              cpu_slice_pkg::OP_LSL: {c_new, res} = {rd_v, 1'b0};
              cpu_slice_pkg::OP_LSR: {res, c_new} = {1'b0, rd_v};
              cpu_slice_pkg::OP_ROL: {c_new, res} = {rd_v, status_flags_register_q[cpu_slice_pkg::FLG_C]};
              cpu_slice_pkg::OP_ROR: {res, c_new} = {status_flags_register_q[cpu_slice_pkg::FLG_C], rd_v};
              default: {res, c_new} = {rd_v[7], rd_v};
            endcase
            regs_d[cmd_q.dst] = res;
            // Overflow after a shift is sign xor carry out.
            status_flags_register_d[cpu_slice_pkg::FLG_C] = c_new;
            status_flags_register_d[cpu_slice_pkg::FLG_Z] = (res == 8'h00);
            status_flags_register_d[cpu_slice_pkg::FLG_N] = res[7];
            status_flags_register_d[cpu_slice_pkg::FLG_V] = res[7] ^ c_new;
          end
          cpu_slice_pkg::OP_SWAP: regs_d[cmd_q.dst] = {rd_v[3:0], rd_v[7:4]};
          cpu_slice_pkg::OP_FLAG_SET: status_flags_register_d[cmd_q.bit_sel] = 1'b1;
          cpu_slice_pkg::OP_FLAG_CLR: status_flags_register_d[cmd_q.bit_sel] = 1'b0;
          cpu_slice_pkg::OP_BST: begin
            status_flags_register_d[cpu_slice_pkg::FLG_T] = regs_q[cmd_q.src][cmd_q.bit_sel];
          end
          cpu_slice_pkg::OP_BLD: begin
            regs_d[cmd_q.dst][cmd_q.bit_sel] = status_flags_register_q[cpu_slice_pkg::FLG_T];
          end
          cpu_slice_pkg::OP_MOV: regs_d[cmd_q.dst] = regs_q[cmd_q.src];
          // pair copy, low bit of indices ignored
          cpu_slice_pkg::OP_REG_PAIR_COPY: begin
            regs_d[{cmd_q.dst[4:1], 1'b0}] = regs_q[{cmd_q.src[4:1], 1'b0}];
            regs_d[{cmd_q.dst[4:1], 1'b1}] = regs_q[{cmd_q.src[4:1], 1'b1}];
          end
          cpu_slice_pkg::OP_LDI: regs_d[cmd_q.dst] = cmd_q.imm;
          cpu_slice_pkg::OP_LD, cpu_slice_pkg::OP_LD_INC,
          cpu_slice_pkg::OP_LD_DEC, cpu_slice_pkg::OP_LD_DISP: begin
            dreq_d.rd = 1'b1;
            dreq_d.addr = ptr;
            state_d = cpu_slice_pkg::ST_EXEC2;
            case (cmd_q.op)
              cpu_slice_pkg::OP_LD_INC: ptr_new = ptr + 16'h0001;
              cpu_slice_pkg::OP_LD_DEC: begin
                ptr_new = ptr - 16'h0001;
                dreq_d.addr = ptr_new;
              end
              cpu_slice_pkg::OP_LD_DISP: dreq_d.addr = ptr + {10'h000, cmd_q.imm[5:0]};
              default: ptr_new = ptr;
            endcase
            regs_d[plo] = ptr_new[7:0];
            regs_d[5'(plo + 5'h01)] = ptr_new[15:8];
          end
          default: begin
          end
        endcase
      end
      cpu_slice_pkg::ST_EXEC2: begin
        state_d = cpu_slice_pkg::ST_IDLE;
        last_d = cpu_slice_pkg::CYC_TWO;
        case (cmd_q.op)
          cpu_slice_pkg::OP_IO_SET: io_d[cmd_q.src][cmd_q.bit_sel] = 1'b1;
          cpu_slice_pkg::OP_IO_CLR: io_d[cmd_q.src][cmd_q.bit_sel] = 1'b0;
          cpu_slice_pkg::OP_LD, cpu_slice_pkg::OP_LD_INC,
          cpu_slice_pkg::OP_LD_DEC, cpu_slice_pkg::OP_LD_DISP: begin
            regs_d[cmd_q.dst] = dmem_rdata_i;
          end
          default: begin
          end
        endcase
      end
      default: state_d = cpu_slice_pkg::ST_IDLE;
    endcase
  end

  // Core registers.
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= cpu_slice_pkg::ST_IDLE;
      cmd_q <= '0;
      dreq_q <= '0;
      pc_q <= cpu_slice_pkg::PC_RST[PC_W-1:0];
      status_flags_register_q <= cpu_slice_pkg::STATUS_FLAGS_REGISTER_RST;
      last_q <= 2'h0;
      regs_q <= '{default: 8'h00};
      io_q <= '{default: 8'h00};
    end else begin
      state_q <= state_d;
      cmd_q <= cmd_d;
      dreq_q <= dreq_d;
      pc_q <= pc_d;
      status_flags_register_q <= status_flags_register_d;
      last_q <= last_d;
      regs_q <= regs_d;
      io_q <= io_d;
    end
  end

endmodule

// ### cpu_exec_checker_asserts.sv
// Port-level assertions for the execution slice.
module cpu_exec_checker #(
  parameter int unsigned PC_W = 16
) (
  // Clock and reset.
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  // Register bus.
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [9:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // Data memory port.
  input wire cpu_slice_pkg::dmem_req_s dmem_req_o,
  input wire logic [7:0] dmem_rdata_i
);
  timeunit 1ns;
  timeprecision 1ps;
  // One clock domain, so every check shares the clock and the reset.
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_b_i);
  //////////////////////////////////////////////////////////////////////////
  // Bus answers come one cycle after the request and last one cycle.
  AST_ACK_NEXT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered in one cycle");
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  AST_ACK_CAUSE: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without a request");
  AST_ACK_IDLE: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("ack while bus idle");
  AST_DAT_QUIET: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack cycle");
  // A load reads once, right after its command was accepted.
  AST_RD_PULSE: assert property (dmem_req_o.rd |=> !dmem_req_o.rd [*2])
    else $error("memory read strobe too long");
  AST_RD_CAUSE: assert property (dmem_req_o.rd |->
    $past(wb_ack_o && wb_we_i && wb_adr_i == cpu_slice_pkg::ADR_CMD))
    else $error("memory read without a command");
  AST_ADDR_HOLD: assert property (!dmem_req_o.rd |-> $stable(dmem_req_o.addr))
    else $error("memory address moved without a read");
endmodule
bind cpu_bit_flag_load_exec cpu_exec_checker #(.PC_W(PC_W)) chk_u (.clk_sys_i, .rst_b_i,
  .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
  .dmem_req_o, .dmem_rdata_i);

// ### data_mem_model.sv
// Behavioural data memory that answers the slice's read strobe.
module data_mem_model (
  // Clock.
  input wire logic clk_sys_i,
  // Read request and data.
  input wire cpu_slice_pkg::dmem_req_s req_i,
  output logic [7:0] rdata_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] last_q = 8'h00;
  // Outside a read the line shows the inverse of the last byte, so stale data fails.
  always_comb begin
    if (req_i.rd) begin
      rdata_o = req_i.addr[7:0] ^ req_i.addr[15:8] ^ 8'hA5;
    end else begin
      rdata_o = ~last_q;
    end
  end
  // Remember what was last delivered.
  always_ff @(posedge clk_sys_i) begin
    if (req_i.rd) begin
      last_q <= rdata_o;
    end
  end
endmodule

// ### cpu_bit_flag_load_exec_bench.sv
// Self-checking bench for the execution slice.
module cpu_bit_flag_load_exec_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic cyc = 1'b0;
  logic we = 1'b0;
  logic [9:0] adr = 10'h000;
  logic [3:0] sel = 4'hF;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic ack;
  logic [7:0] mdat;
  cpu_slice_pkg::dmem_req_s dreq;
  int err_count = 0;
  int n_tests = 0;
  // Strobe follows cycle; the slice never sees one without the other.
  cpu_bit_flag_load_exec dut_u (.clk_sys_i(clk_sys), .rst_b_i(rst_b), .wb_cyc_i(cyc),
    .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .dmem_req_o(dreq), .dmem_rdata_i(mdat));
  data_mem_model mem_u (.clk_sys_i(clk_sys), .req_i(dreq), .rdata_o(mdat));
  // Clock of 25 ns.
  initial begin
    forever #12.5 clk_sys = ~clk_sys;
  end
  //////////////////////////////////////////////////////////////////////////
  // Address helpers and the memory's expected contents.
  function automatic logic [9:0] ra(input logic [4:0] n);
    return {cpu_slice_pkg::BANK_REGS, n, 2'h0};
  endfunction
  function automatic logic [9:0] ia(input logic [4:0] n);
    return {cpu_slice_pkg::BANK_IO, n, 2'h0};
  endfunction
  function automatic logic [7:0] mb(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'hA5;
  endfunction
  // Compare and count.
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      err_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // One classic cycle, held until ack is seen, then released for a cycle.
  task automatic bus(input logic w, input logic [9:0] a, input logic [31:0] d,
    output logic [31:0] q);
    int n;
    n = 0;
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk_sys);
      n++;
    end while (ack !== 1'b1 && n < 40);
    // A request that is never answered counts against the run.
    if (ack !== 1'b1) begin
      err_count++;
    end
    q = rdat;
    cyc <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rdc(input logic [9:0] a, input logic [15:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk({16'h0, q[15:0]}, {16'h0, e});
  endtask
  // Issue one instruction, then read back busy and its cycle count.
  task automatic ex(input logic [4:0] o, input logic [4:0] d, input logic [4:0] s,
    input logic [2:0] b, input logic [7:0] i, input logic [1:0] cy);
    cpu_slice_pkg::cmd_s c;
    logic [31:0] q;
    c = '{6'h00, i, b, s, d, cpu_slice_pkg::op_e'(o)};
    bus(1'b1, cpu_slice_pkg::ADR_CMD, c, q);
    bus(1'b0, cpu_slice_pkg::ADR_STATUS, 32'h0, q);
    chk({29'h0, q[9:8], q[0]}, {29'h0, cy, 1'b0});
  endtask
  //////////////////////////////////////////////////////////////////////////
  // Reset values, an unmapped place and a partial-lane command.
  task automatic t_reset();
    rdc(cpu_slice_pkg::ADR_PC, 16'h0);
    rdc(cpu_slice_pkg::ADR_STATUS_FLAGS_REGISTER, 16'h0);
    wr(10'h3FC, 32'hFF);
    rdc(10'h3FC, 16'h0);
    sel <= 4'h1;
    wr(cpu_slice_pkg::ADR_CMD, 32'h13);
    sel <= 4'hF;
    rdc(cpu_slice_pkg::ADR_PC, 16'h0);
    $display("reset test done");
  endtask
  // Shifts, rotates and swap on two operands, carry in set.
  task automatic t_shift();
    logic [7:0] v;
    logic [7:0] r;
    logic c;
    for (int j = 0; j < 2; j++) begin
      for (int o = 7; o <= 12; o++) begin
        v = j ? 8'h80 : 8'h81;
        c = 1'b1;
        case (o)
          7: {c, r} = {v, 1'b0};
          8: {r, c} = {1'b0, v};
          9: {c, r} = {v, 1'b1};
          10: {r, c} = {1'b1, v};
          11: {r, c} = {v[7], v};
          default: r = {v[3:0], v[7:4]};
        endcase
        wr(cpu_slice_pkg::ADR_STATUS_FLAGS_REGISTER, 32'h31);
        wr(ra(5'h14), {24'h0, v});
        ex(5'(o), 5'h14, 5'h0, 3'h0, 8'h0, 2'h1);
        rdc(ra(5'h14), {8'h0, r});
        rdc(cpu_slice_pkg::ADR_STATUS_FLAGS_REGISTER, (o == 12) ? 16'h31 :
          {8'h0, 4'h3, r[7] ^ c, r[7], r == 8'h0, c});
      end
    end
    $display("shift test done");
  endtask
  // Every status bit set alone and cleared alone, then transfer bit moves.
  task automatic t_flags();
    for (int b = 0; b < 8; b++) begin
      wr(cpu_slice_pkg::ADR_STATUS_FLAGS_REGISTER, 32'h0);
      ex(5'h0D, 5'h0, 5'h0, 3'(b), 8'h0, 2'h1);
      rdc(cpu_slice_pkg::ADR_STATUS_FLAGS_REGISTER, {8'h0, 8'h01 << b});
      wr(cpu_slice_pkg::ADR_STATUS_FLAGS_REGISTER, 32'hFF);
      ex(5'h0E, 5'h0, 5'h0, 3'(b), 8'h0, 2'h1);
      rdc(cpu_slice_pkg::ADR_STATUS_FLAGS_REGISTER, {8'h0, ~(8'h01 << b)});
    end
    wr(cpu_slice_pkg::ADR_STATUS_FLAGS_REGISTER, 32'h0);
    wr(ra(5'h03), 32'h10);
    wr(ra(5'h04), 32'h0);
    ex(5'h0F, 5'h0, 5'h03, 3'h4, 8'h0, 2'h1);
    ex(5'h10, 5'h04, 5'h0, 3'h2, 8'h0, 2'h1);
    rdc(ra(5'h04), 16'h04);
    rdc(cpu_slice_pkg::ADR_STATUS_FLAGS_REGISTER, 16'h40);
    $display("flag test done");
  endtask
  // Flag branches, taken and not, with a backward offset.
  task automatic t_branch();
    logic tk;
    logic [7:0] s;
    for (int o = 1; o <= 4; o++) begin
      for (int f = 0; f < 2; f++) begin
        s = 8'(f) << ((o < 3) ? cpu_slice_pkg::FLG_V : cpu_slice_pkg::FLG_I);
        tk = (o % 2) ? f[0] : !f[0];
        wr(cpu_slice_pkg::ADR_PC, 32'h10);
        wr(cpu_slice_pkg::ADR_STATUS_FLAGS_REGISTER, {24'h0, s});
        ex(5'(o), 5'h0, 5'h0, 3'h0, 8'h7E, tk ? 2'h2 : 2'h1);
        rdc(cpu_slice_pkg::ADR_PC, tk ? 16'h0F : 16'h11);
        rdc(cpu_slice_pkg::ADR_STATUS_FLAGS_REGISTER, {8'h0, s});
      end
    end
    $display("branch test done");
  endtask
  // I/O bit set and clear on the top index.
  task automatic t_io();
    wr(cpu_slice_pkg::ADR_STATUS_FLAGS_REGISTER, 32'h55);
    wr(ia(5'h1F), 32'hA0);
    ex(5'h05, 5'h0, 5'h1F, 3'h0, 8'h0, 2'h2);
    rdc(ia(5'h1F), 16'hA1);
    ex(5'h06, 5'h0, 5'h1F, 3'h7, 8'h0, 2'h2);
    rdc(ia(5'h1F), 16'h21);
    rdc(cpu_slice_pkg::ADR_STATUS_FLAGS_REGISTER, 16'h55);
    $display("io test done");
  endtask
  // Pointer loads, pre-decrement wrapping below zero.
  task automatic t_load();
    wr(cpu_slice_pkg::ADR_STATUS_FLAGS_REGISTER, 32'hAA);
    wr(ra(5'h1A), 32'h0);
    wr(ra(5'h1B), 32'h01);
    ex(5'h15, 5'h02, 5'h0, 3'h0, 8'h0, 2'h2);
    rdc(ra(5'h02), {8'h0, mb(16'h0100)});
    rdc(ra(5'h1A), 16'h01);
    wr(ra(5'h1C), 32'h0);
    wr(ra(5'h1D), 32'h0);
    ex(5'h16, 5'h03, 5'h01, 3'h0, 8'h0, 2'h2);
    rdc(ra(5'h03), {8'h0, mb(16'hFFFF)});
    rdc(ra(5'h1D), 16'hFF);
    wr(ra(5'h1E), 32'h0);
    wr(ra(5'h1F), 32'h03);
    ex(5'h17, 5'h05, 5'h02, 3'h0, 8'h3F, 2'h2);
    rdc(ra(5'h05), {8'h0, mb(16'h033F)});
    rdc(ra(5'h1E), 16'h0);
    rdc(cpu_slice_pkg::ADR_STATUS_FLAGS_REGISTER, 16'hAA);
    $display("load test done");
  endtask
  // Immediate load, move and pair copy.
  task automatic t_move();
    ex(5'h13, 5'h10, 5'h0, 3'h0, 8'hC3, 2'h1);
    ex(5'h13, 5'h11, 5'h0, 3'h0, 8'h3C, 2'h1);
    ex(5'h11, 5'h06, 5'h10, 3'h0, 8'h0, 2'h1);
    ex(5'h12, 5'h08, 5'h10, 3'h0, 8'h0, 2'h1);
    rdc(ra(5'h06), 16'hC3);
    rdc(ra(5'h08), 16'hC3);
    rdc(ra(5'h09), 16'h3C);
    rdc(cpu_slice_pkg::ADR_STATUS_FLAGS_REGISTER, 16'hAA);
    $display("move test done");
  endtask
  // Verdict and end of run.
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Main sequence after three cycles of reset and the release delay.
  initial begin
    repeat (3) @(posedge clk_sys);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk_sys);
    t_reset();
    t_shift();
    t_flags();
    t_branch();
    t_io();
    t_load();
    t_move();
    test_done();
  end
  // Watchdog well beyond the several hundred cycles the tests need.
  initial begin
    repeat (20000) @(posedge clk_sys);
    err_count++;
    test_done();
  end
endmodule
